// ---- rtl/cbm_defs.svh ----
// constant definitions for the cpu board memory decode and dram control block
`ifndef CBM_DEFS_SVH
`define CBM_DEFS_SVH

`define CBM_CLK_DIV          6
`define CBM_CLK_HALF         3
`define CBM_DIV_W            3
`define CBM_MASTER_KHZ       10644
`define CBM_CPU_KHZ          1774
`define CBM_DLY_STAGES       3
`define CBM_MUX_STAGE        1
`define CBM_CAS_STAGE        2
`define CBM_RAM_ROW_LSB      0
`define CBM_RAM_COL_LSB      7
`define CBM_RAM_LINES        7
`define CBM_PAT_ROM1         4'h0
`define CBM_PAT_ROM2         4'h1
`define CBM_PAT_ROM3         4'h2
`define CBM_PAT_IOMAP        4'h3
`define CBM_PAT_KBD          2'h2
`define CBM_PAT_VID          2'h3
`define CBM_PAT_RAM_HI       2'h1
`define CBM_PAT_RAM_4K       2'h0

`endif

// ---- rtl/cbm_pkg.sv ----
// types shared by the memory decode and dram control files
package cbm_pkg;
  typedef enum logic [2:0] {
    CBM_SEL_NONE,
    CBM_SEL_ROM1,
    CBM_SEL_ROM2,
    CBM_SEL_ROM3,
    CBM_SEL_KBD,
    CBM_SEL_VID,
    CBM_SEL_RAM
  } cbm_sel_t;
endpackage

// ---- rtl/cbm_clk_div.sv ----
// divide-by-six processor clock generator
`timescale 1ns/1ps
`include "cbm_defs.svh"
module cbm_clk_div
  import cbm_pkg::*;
#(
  parameter int DIV = `CBM_CLK_DIV
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  output logic      cpu_clk_o
);
  logic [`CBM_DIV_W-1:0] count;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      count <= '0;
    end else if (count == `CBM_DIV_W'(DIV - 1)) begin
      count <= '0;
    end else begin
      count <= count + `CBM_DIV_W'(1);
    end
  end

  // equal high and low halves keep the duty at fifty percent
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cpu_clk_o <= 1'b0;
    end else begin
      cpu_clk_o <= (count >= `CBM_DIV_W'(DIV / 2)) ? 1'b0 : 1'b1;
    end
  end
endmodule

// ---- rtl/cbm_addr_decode.sv ----
// upper address decode into device selects
`timescale 1ns/1ps
`include "cbm_defs.svh"
module cbm_addr_decode
  import cbm_pkg::*;
(
  input  wire logic [15:10] addr_hi_i,
  input  wire logic         ram_16k_i,
  output cbm_sel_t          sel_o
);
  always_comb begin
    sel_o = CBM_SEL_NONE;
    if (addr_hi_i[15:14] == `CBM_PAT_RAM_HI) begin
      if (ram_16k_i || addr_hi_i[13:12] == `CBM_PAT_RAM_4K) begin
        sel_o = CBM_SEL_RAM;
      end
    end else begin
      case (addr_hi_i[15:12])
        `CBM_PAT_ROM1: sel_o = CBM_SEL_ROM1;
        `CBM_PAT_ROM2: sel_o = CBM_SEL_ROM2;
        `CBM_PAT_ROM3: sel_o = CBM_SEL_ROM3;
        `CBM_PAT_IOMAP: begin
          if (addr_hi_i[11:10] == `CBM_PAT_KBD) begin
            sel_o = CBM_SEL_KBD;
          end else if (addr_hi_i[11:10] == `CBM_PAT_VID) begin
            sel_o = CBM_SEL_VID;
          end
        end
        default: sel_o = CBM_SEL_NONE;
      endcase
    end
  end
endmodule

// ---- rtl/cbm_mem_ctrl.sv ----
// cpu board bus buffering, device decode and dram strobe generation
// How it works
// - master clock divided by six for processor
// - read: inbound data on, outbound off
// - isolate low disables address and outbound data
// - control bus decoded into four strobes
// - 0000/0001/0010 select roms one to three
// - 0011 with 10 keyboard, 11 video
// - ram on 01; 4k needs 00 too
// - fourteen ram address bits on seven lines
// - mux low drives row bits 0-6
// - mux high drives column bits 7-13
// - row strobe equals memory request directly
// - read or write feeds three-stage delay chain
// - mux select rises two clocks after request
// - column strobe one clock after mux
// - strobes inactive clear chain at next clock
// - column strobe gated by ram select
// - ram read enables ram data buffers
// - ram write drives write low, buffers off
`timescale 1ns/1ps
`include "cbm_defs.svh"
module cbm_mem_ctrl
  import cbm_pkg::*;
#(
  parameter int STAGES = `CBM_DLY_STAGES
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  output logic             cpu_clk_o,
  // processor side
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [7:0]  cpu_data_i,
  output logic [7:0]       cpu_data_o,
  output logic             cpu_data_oe_o,
  input  wire logic        memory_request_n_i,
  input  wire logic        io_request_n_i,
  input  wire logic        cpu_rd_n_i,
  input  wire logic        cpu_wr_n_i,
  input  wire logic        bus_isolate_n_i,
  input  wire logic        ram_16k_i,
  // system side
  output logic [15:0]      sys_addr_o,
  output logic             sys_addr_oe_o,
  input  wire logic [7:0]  sys_data_i,
  output logic [7:0]       sys_data_o,
  output logic             sys_data_oe_o,
  output logic             mem_write_strobe_n_o,
  output logic             mem_read_strobe_n_o,
  output logic             io_in_strobe_n_o,
  output logic             io_out_strobe_n_o,
  output logic             rom1_sel_n_o,
  output logic             rom2_sel_n_o,
  output logic             rom3_sel_n_o,
  output logic             kbd_sel_n_o,
  output logic             vid_sel_n_o,
  output logic             ram_sel_n_o,
  // dram side
  output logic [6:0]       ram_addr_o,
  output logic             ram_row_strobe_n_o,
  output logic             ram_col_strobe_n_o,
  output logic             ram_mux_sel_o,
  output logic             ram_write_n_o,
  input  wire logic [7:0]  ram_data_i,
  output logic [7:0]       ram_data_o,
  output logic             ram_rd_buf_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // processor clock

  cbm_clk_div #(
    .DIV (`CBM_CLK_DIV)
  ) u_clk_div (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .cpu_clk_o  (cpu_clk_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control bus decode

  logic     cpu_reading;
  logic     access_req;
  cbm_sel_t dev_sel;
  logic     ram_hit;

  assign mem_write_strobe_n_o = memory_request_n_i | cpu_wr_n_i;
  assign mem_read_strobe_n_o  = memory_request_n_i | cpu_rd_n_i;
  assign io_in_strobe_n_o     = io_request_n_i | cpu_rd_n_i;
  assign io_out_strobe_n_o    = io_request_n_i | cpu_wr_n_i;

  assign cpu_reading = ~cpu_rd_n_i;
  // refresh carries neither read nor write, so it never starts the chain
  assign access_req  = ~mem_read_strobe_n_o | ~mem_write_strobe_n_o;

  ////////////////////////////////////////////////////////////////////////////
  // address and data buffers

  assign sys_addr_o    = cpu_addr_i;
  assign sys_addr_oe_o = bus_isolate_n_i;

  // outbound carries processor data whenever not reading and not isolated
  assign sys_data_o    = cpu_data_i;
  assign sys_data_oe_o = ~cpu_reading & bus_isolate_n_i;

  // inbound: ram buffers share the system data bus on reads
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cpu_data_o <= 8'h00;
    end else if (ram_rd_buf_en_o) begin
      cpu_data_o <= ram_data_i;
    end else begin
      cpu_data_o <= sys_data_i;
    end
  end

  assign cpu_data_oe_o = cpu_reading;

  ////////////////////////////////////////////////////////////////////////////
  // device selects

  cbm_addr_decode u_decode (
    .addr_hi_i (cpu_addr_i[15:10]),
    .ram_16k_i (ram_16k_i),
    .sel_o     (dev_sel)
  );

  assign ram_hit      = (dev_sel == CBM_SEL_RAM);
  assign rom1_sel_n_o = ~(dev_sel == CBM_SEL_ROM1);
  assign rom2_sel_n_o = ~(dev_sel == CBM_SEL_ROM2);
  assign rom3_sel_n_o = ~(dev_sel == CBM_SEL_ROM3);
  assign kbd_sel_n_o  = ~(dev_sel == CBM_SEL_KBD);
  assign vid_sel_n_o  = ~(dev_sel == CBM_SEL_VID);
  assign ram_sel_n_o  = ~ram_hit;

  ////////////////////////////////////////////////////////////////////////////
  // mux / column strobe delay chain

  logic [STAGES-1:0] dly;
  logic [STAGES-1:0] dly_in;

  // the head flop takes the request, every later flop the one before it;
  // a shifted copy keeps a constant out-of-range index out of stage zero
  assign dly_in = {dly[STAGES-2:0], 1'b1};

  // one flop per stage; a dropped request clears the chain at the next edge,
  // the combinational gate below removes the strobes before the next edge
  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++) begin : g_dly
      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !access_req) begin
          dly[gi] <= 1'b0;
        end else begin
          dly[gi] <= dly_in[gi];
        end
      end
    end
  endgenerate

  // stage one tap gives the mux two clocks after request, stage two one more
  assign ram_mux_sel_o = dly[`CBM_MUX_STAGE] & access_req;

  logic col_strobe_n;
  assign col_strobe_n       = ~(dly[`CBM_CAS_STAGE] & access_req);
  assign ram_col_strobe_n_o = col_strobe_n | ~ram_hit;

  ////////////////////////////////////////////////////////////////////////////
  // dram address and strobes

  // row address also carries the processor's refresh row
  assign ram_addr_o = ram_mux_sel_o ?
      cpu_addr_i[`CBM_RAM_COL_LSB +: `CBM_RAM_LINES] :
      cpu_addr_i[`CBM_RAM_ROW_LSB +: `CBM_RAM_LINES];

  assign ram_row_strobe_n_o = memory_request_n_i;

  assign ram_write_n_o   = mem_write_strobe_n_o;
  assign ram_data_o      = cpu_data_i;
  assign ram_rd_buf_en_o = ram_hit & ~mem_read_strobe_n_o;

endmodule

// ---- sim/cbm_mem_ctrl_sva.sv ----
// concurrent checks on the dram strobes, bus buffers and processor clock
`timescale 1ns/1ps
module cbm_mem_ctrl_sva (
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        cpu_clk_o,
  input wire logic [15:0] cpu_addr_i,
  input wire logic        memory_request_n_i,
  input wire logic        cpu_rd_n_i,
  input wire logic        cpu_wr_n_i,
  input wire logic        bus_isolate_n_i,
  input wire logic        sys_addr_oe_o,
  input wire logic        sys_data_oe_o,
  input wire logic        cpu_data_oe_o,
  input wire logic        ram_sel_n_o,
  input wire logic [6:0]  ram_addr_o,
  input wire logic        ram_row_strobe_n_o,
  input wire logic        ram_col_strobe_n_o,
  input wire logic        ram_mux_sel_o
);
  wire acc = !memory_request_n_i && !(cpu_rd_n_i && cpu_wr_n_i);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_clk_div_six: assert property ($rose(cpu_clk_o) |=>
    cpu_clk_o[*2] ##1 !cpu_clk_o[*3] ##1 cpu_clk_o) else $error("clock divide wrong");
  a_row_is_memory_request_n: assert property (ram_row_strobe_n_o == memory_request_n_i)
    else $error("row strobe differs from request");
  a_mux_two_clk: assert property ($rose(acc) |->
    !ram_mux_sel_o ##1 !ram_mux_sel_o ##1 (ram_mux_sel_o == acc)) else $error("mux delay");
  a_col_after_mux: assert property ($rose(ram_mux_sel_o) |-> ram_col_strobe_n_o ##1
    (ram_col_strobe_n_o == (ram_sel_n_o || !acc))) else $error("col strobe delay");
  a_drop_clears: assert property (!acc |-> !ram_mux_sel_o && ram_col_strobe_n_o)
    else $error("strobes not cleared");
  a_col_needs_ram: assert property (!ram_col_strobe_n_o |->
    $past(ram_mux_sel_o) && ram_mux_sel_o && !ram_sel_n_o) else $error("col without ram");
  a_ram_addr_mux: assert property (ram_addr_o ==
    (ram_mux_sel_o ? cpu_addr_i[13:7] : cpu_addr_i[6:0])) else $error("ram address mux");
  a_data_dir: assert property (cpu_data_oe_o != cpu_rd_n_i &&
    sys_data_oe_o == (cpu_rd_n_i && bus_isolate_n_i)) else $error("data buffer direction");
  a_addr_isolate: assert property (sys_addr_oe_o == bus_isolate_n_i)
    else $error("address buffer isolate");
  c_ram_col: cover property (!ram_col_strobe_n_o);
  c_refresh: cover property (!memory_request_n_i && !acc);
  c_isolate: cover property (!bus_isolate_n_i && !cpu_wr_n_i);
endmodule
bind cbm_mem_ctrl cbm_mem_ctrl_sva cbm_mem_ctrl_sva_inst (.*);

// ---- sim/cbm_cpu_model.sv ----
// processor bus master model: memory, io and refresh cycles
`timescale 1ns/1ps
module cbm_cpu_model (
  input  wire logic        clk_i,
  input  wire logic [2:0]  op_i,
  input  wire logic [15:0] a_i,
  input  wire logic [3:0]  hold_i,
  output logic [15:0]      addr_o,
  output logic             memory_request_n_n_o,
  output logic             iorq_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic             busy_o
);
  logic [6:0] row = 7'h00;
  logic [3:0] cnt = 4'h0;
  initial begin
    addr_o = 16'h0000;
    {memory_request_n_n_o, iorq_n_o, rd_n_o, wr_n_o, busy_o} = 5'h1E;
  end
  // op bit 2 picks io; low bits 1 read, 2 write, 3 refresh; stands hold_i+1 cycles
  always @(posedge clk_i) begin
    if (busy_o && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy_o) begin
      // released lines must not keep their last value
      {memory_request_n_n_o, iorq_n_o, rd_n_o, wr_n_o, busy_o} <= 5'h1E;
      addr_o <= ~addr_o;
    end else if (op_i != 3'h0) begin
      {busy_o, cnt, memory_request_n_n_o, iorq_n_o} <= {1'b1, hold_i, op_i[2], !op_i[2]};
      rd_n_o <= op_i[1:0] != 2'h1;
      wr_n_o <= op_i[1:0] != 2'h2;
      addr_o <= (op_i[1:0] == 2'h3) ? {9'h000, row} : a_i;
      if (op_i[1:0] == 2'h3) row <= row + 7'h01;
    end
  end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the memory decode and dram strobe block
`timescale 1ns/1ps
module testbench;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, bus_isolate_n_i = 1'b1, ram_16k_i = 1'b1;
  logic [7:0] cpu_data_i = 8'h3C, sys_data_i = 8'h5A, ram_data_i = 8'hA5;
  logic [7:0] cpu_data_o, sys_data_o, ram_data_o;
  logic [15:0] cpu_addr_i, sys_addr_o, a = 16'h0000;
  logic [6:0] ram_addr_o;
  logic [2:0] op = 3'h0;
  logic [3:0] hold = 4'h0;
  logic memory_request_n_i, io_request_n_i, cpu_rd_n_i, cpu_wr_n_i, busy, cpu_clk_o;
  logic cpu_data_oe_o, sys_addr_oe_o, sys_data_oe_o, mem_write_strobe_n_o, mem_read_strobe_n_o;
  logic io_in_strobe_n_o, io_out_strobe_n_o, rom1_sel_n_o, rom2_sel_n_o, rom3_sel_n_o;
  logic kbd_sel_n_o, vid_sel_n_o, ram_sel_n_o, ram_row_strobe_n_o, ram_col_strobe_n_o;
  logic ram_mux_sel_o, ram_write_n_o, ram_rd_buf_en_o;
  int miscompares = 0, n_compared = 0;
  always #2 core_clk_i = ~core_clk_i;
  cbm_mem_ctrl cbm_mem_ctrl_inst (.*);
  cbm_cpu_model cbm_cpu_model_inst (.clk_i(core_clk_i), .op_i(op), .a_i(a), .hold_i(hold),
    .addr_o(cpu_addr_i), .memory_request_n_n_o(memory_request_n_i), .iorq_n_o(io_request_n_i),
    .rd_n_o(cpu_rd_n_i), .wr_n_o(cpu_wr_n_i), .busy_o(busy));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // returns at the falling edge of the first cycle the request stands
  task automatic go(logic [2:0] o, logic [15:0] ad, logic [3:0] h);
    @(posedge core_clk_i);
    {op, a, hold} <= {o, ad, h};
    @(posedge core_clk_i);
    op <= 3'h0;
    @(negedge core_clk_i);
  endtask
  task automatic idle;
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge core_clk_i);
    if (busy !== 1'b0) begin
      chk("idle", 16'h0000, 16'h0001);
      end_of_test();
    end
  endtask
  // jumper, expected select index (6 none) and address
  localparam logic [19:0] DT [10] = '{20'h80000, 20'h91C00, 20'hA2C00, 20'hB3800,
    20'hC3C00, 20'hE3400, 20'hD7FFF, 20'h54FFF, 20'h65000, 20'hE8000};
  task automatic t_decode;
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_i) ram_16k_i <= DT[i][19];
      go(3'h1, DT[i][15:0], 4'h0);
      chk("sel", {10'h000, ~(6'h20 >> DT[i][18:16])}, {10'h000, rom1_sel_n_o, rom2_sel_n_o,
        rom3_sel_n_o, kbd_sel_n_o, vid_sel_n_o, ram_sel_n_o});
      idle();
    end
    @(posedge core_clk_i) ram_16k_i <= 1'b1;
  endtask
  // ram read then rom read, looked at once the column strobe time has come
  task automatic t_read;
    for (int r = 0; r < 2; r++) begin
      go(3'h1, r ? 16'h0100 : 16'h4ABC, 4'h6);
      chk("strobes", 16'h000B, {12'h000, mem_write_strobe_n_o, mem_read_strobe_n_o,
        io_in_strobe_n_o, io_out_strobe_n_o});
      repeat (3) @(negedge core_clk_i);
      chk("rd col", r ? 16'h0001 : 16'h0000, {15'h0000, ram_col_strobe_n_o});
      chk("rd buf", r ? 16'h0100 : 16'h0101, {7'h00, ram_write_n_o, 7'h00, ram_rd_buf_en_o});
      chk("rd data", r ? 16'h005A : 16'h00A5, {8'h00, cpu_data_o});
      idle();
    end
  endtask
  task automatic t_write_isolate;
    @(posedge core_clk_i) bus_isolate_n_i <= 1'b0;
    go(3'h2, 16'h7123, 4'h4);
    chk("strobes", 16'h0007, {12'h000, mem_write_strobe_n_o, mem_read_strobe_n_o,
      io_in_strobe_n_o, io_out_strobe_n_o});
    chk("wr", 16'h3C00, {ram_data_o, 4'h0, ram_write_n_o, ram_rd_buf_en_o,
      sys_addr_oe_o, sys_data_oe_o});
    chk("sys addr", 16'h7123, sys_addr_o);
    chk("sys data", 16'h003C, {8'h00, sys_data_o});
    idle();
    @(posedge core_clk_i) bus_isolate_n_i <= 1'b1;
  endtask
  task automatic t_refresh_io;
    for (int k = 0; k < 3; k++) begin
      go(3'h3, 16'h4000, 4'h4);
      repeat (3) @(negedge core_clk_i);
      chk("refresh", {k[6:0], 9'h002}, {ram_addr_o, 6'h00, ram_mux_sel_o, ram_col_strobe_n_o,
        ram_row_strobe_n_o});
      idle();
    end
    for (int k = 5; k < 7; k++) begin
      go(k[2:0], 16'h4000, 4'h4);
      repeat (3) @(negedge core_clk_i);
      chk("io", k == 5 ? 16'h0007 : 16'h000B, {12'h000, io_in_strobe_n_o, io_out_strobe_n_o,
        mem_read_strobe_n_o, ram_col_strobe_n_o});
      idle();
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_decode();
    t_read();
    t_write_isolate();
    t_refresh_io();
    end_of_test();
  end
endmodule
